// [rtl/mcd_pkg.sv]
// constants and types shared by the motion command decoder
package mcd_pkg;
  localparam logic [31:0] CMD_JOG_LEFT = 32'h7466656C;
  localparam logic [31:0] CMD_BACKLASH = 32'h74666F6C;
  localparam logic [31:0] CMD_GOTO = 32'h65766F6D;
  localparam logic [31:0] CMD_SHIFT = 32'h72766F6D;
  localparam logic [31:0] CMD_PWR_OFF = 32'h666F7770;
  localparam logic [31:0] CMD_ANALOG = 32'h6E616472;
  localparam logic [4:0] LEN_SHORT = 5'h04;
  localparam logic [4:0] LEN_MOVE = 5'h12;
  localparam logic [6:0] LEN_ECHO = 7'h04;
  localparam logic [6:0] LEN_ANALOG = 7'h4C;
  localparam logic [4:0] CODE_LAST = 5'h03;
  localparam logic [4:0] PAY_FIRST = 5'h04;
  localparam logic [4:0] PAY_LAST = 5'h09;
  localparam int ADC_CH = 13;
  localparam int ANS_BITS = 608;
  localparam int RAW_POS = 4;
  localparam int CAL_POS = 30;
  localparam int RES_POS = 58;
  localparam int IND_POS = 62;
  localparam int CRC_POS = 74;
  localparam logic [15:0] UNUSED_WORD = 16'h0000;
  localparam logic [15:0] CRC_FILL = 16'h0000;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [6:0] IDX_RST = 7'h00;

  typedef enum logic [0:0] {
    ST_COLLECT = 1'b0,
    ST_SEND = 1'b1
  } mcd_state_t;

  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_AWAY = 2'b01,
    BK_BACK = 2'b10
  } mcd_bk_state_t;
endpackage

// [rtl/mcd_decoder.sv]
// motion command decoder: frame collection, dispatch and answers
// Function
// - jog-left frame starts left motion, echoes code
// - backlash: move away by distance, then return
// - goto frame is 18 bytes with target fields
// - goto uses the frame's target fields; fraction dropped for dc
// - shift frame is 18 bytes with delta fields
// - shift direction from delta sign; dc drops fraction
// - power-off cuts motor power immediately
// - analog readout answers with 76 bytes
// - calibrated values pass in documented units
// - readout ends resistance, inductance, reserved, checksum
`timescale 1ns/10ps
`default_nettype none
module mcd_decoder
  import mcd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic motor_is_dc_i,
  input wire logic [31:0] backlash_dist_i,
  input wire logic [31:0] cur_pos_i,
  input wire logic [15:0] cur_frac_i,
  input wire logic motion_done_i,
  input wire logic [ADC_CH*16-1:0] adc_raw_i,
  input wire logic [ADC_CH*16-1:0] adc_cal_i,
  input wire logic [31:0] wind_res_i,
  input wire logic [31:0] wind_ind_i,
  output logic jog_left_o,
  output logic move_abs_o,
  output logic move_rel_o,
  output logic power_off_o,
  output logic [31:0] goto_pos_o,
  output logic [15:0] target_microstep_frac_o,
  output logic [31:0] shift_steps_o,
  output logic [15:0] shift_microstep_frac_o,
  output logic shift_dir_left_o
);
  mcd_state_t st_r;
  mcd_bk_state_t bk_r;
  logic [4:0] cnt_r;
  logic [31:0] code_r;
  logic [47:0] pay_r;
  logic [6:0] tx_idx_r;
  logic [6:0] tx_len_r;
  logic [ANS_BITS-1:0] ans_r;
  logic tx_valid_r;
  logic [7:0] tx_byte_r;
  logic [31:0] bk_pos_r;
  logic [15:0] bk_frac_r;
  logic jog_r;
  logic abs_r;
  logic rel_r;
  logic pwr_r;
  logic dir_r;
  logic [31:0] goto_r;
  logic [31:0] steps_r;
  logic [15:0] tfrac_r;
  logic [15:0] sfrac_r;
  mcd_bk_state_t bk_nxt;

  // decode of the arriving frame
  wire logic take_w = rx_valid_i && (st_r == ST_COLLECT);
  wire logic [31:0] code_nxt_w = {rx_data_i, code_r[31:8]};
  wire logic is_long_w = (code_nxt_w == CMD_GOTO) || (code_nxt_w == CMD_SHIFT);
  wire logic is_short_w = (code_nxt_w == CMD_JOG_LEFT) || (code_nxt_w == CMD_BACKLASH) ||
                          (code_nxt_w == CMD_PWR_OFF) || (code_nxt_w == CMD_ANALOG);
  wire logic at_code_w = (cnt_r == CODE_LAST);
  wire logic done_short_w = take_w && at_code_w && is_short_w;
  wire logic done_long_w = take_w && (cnt_r == LEN_MOVE - 5'h01);
  wire logic done_w = done_short_w || done_long_w;
  wire logic [31:0] cmd_w = at_code_w ? code_nxt_w : code_r;
  wire logic [31:0] pos_w = pay_r[31:0];
  wire logic [15:0] frac_w = motor_is_dc_i ? 16'h0000 : pay_r[47:32];
  wire logic cmd_jog_w = done_w && (cmd_w == CMD_JOG_LEFT);
  wire logic cmd_bk_w = done_w && (cmd_w == CMD_BACKLASH);
  wire logic cmd_goto_w = done_w && (cmd_w == CMD_GOTO);
  wire logic cmd_shift_w = done_w && (cmd_w == CMD_SHIFT);
  wire logic cmd_pwr_w = done_w && (cmd_w == CMD_PWR_OFF);
  wire logic cmd_adc_w = done_w && (cmd_w == CMD_ANALOG);
  wire logic bk_abort_w = cmd_jog_w || cmd_goto_w || cmd_shift_w;
  wire logic tx_adv_w = !tx_valid_r || tx_ready_i;
  wire logic tx_more_w = (tx_idx_r < tx_len_r);
  wire logic [7:0] tx_sel_w = ans_r[{tx_idx_r, 3'b000} +: 8];

  // readout answer image, byte 0 first, words little-endian
  logic [ANS_BITS-1:0] adc_img_w;
  genvar gi;
  generate
    for (gi = 0; gi < ADC_CH; gi = gi + 1) begin : g_adc
      assign adc_img_w[(RAW_POS+2*gi)*8 +: 16] = adc_raw_i[gi*16 +: 16];
      assign adc_img_w[(CAL_POS+2*gi)*8 +: 16] = adc_cal_i[gi*16 +: 16];
    end
  endgenerate
  assign adc_img_w[31:0] = CMD_ANALOG;
  assign adc_img_w[(CAL_POS+2*ADC_CH)*8 +: 16] = UNUSED_WORD;
  assign adc_img_w[RES_POS*8 +: 32] = wind_res_i;
  assign adc_img_w[IND_POS*8 +: 32] = wind_ind_i;
  assign adc_img_w[IND_POS*8+32 +: 64] = 64'h0000000000000000;
  // checksum generation lives outside this block; field sent as fill
  assign adc_img_w[CRC_POS*8 +: 16] = CRC_FILL;

  // frame collection; no new frame is taken while an answer drains
  wire logic code_en_w = take_w && (cnt_r < PAY_FIRST);
  wire logic pay_en_w = take_w && (cnt_r >= PAY_FIRST) && (cnt_r <= PAY_LAST);

  // unknown codes restart at byte 0 rather than swallowing a long frame
  wire logic cnt_clr_w = done_w || (at_code_w && !is_long_w);
  wire logic [4:0] cnt_nxt = cnt_clr_w ? CNT_RST : cnt_r + 5'h01;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_r <= CNT_RST;
    end else if (take_w) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      code_r <= 32'h00000000;
    end else if (code_en_w) begin
      code_r <= code_nxt_w;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pay_r <= 48'h000000000000;
    end else if (pay_en_w) begin
      pay_r <= {rx_data_i, pay_r[47:8]};
    end
  end

  // answer image is a snapshot taken at frame completion
  wire logic load_w = (st_r == ST_COLLECT) && done_w;
  wire logic [ANS_BITS-1:0] ans_nxt = cmd_adc_w ? adc_img_w : {{(ANS_BITS-32){1'b0}}, cmd_w};
  wire logic [6:0] len_nxt = cmd_adc_w ? LEN_ANALOG : LEN_ECHO;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ans_r <= '0;
      tx_len_r <= IDX_RST;
    end else if (load_w) begin
      ans_r <= ans_nxt;
      tx_len_r <= len_nxt;
    end
  end

  // answer sequencing
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r <= ST_COLLECT;
      tx_idx_r <= IDX_RST;
      tx_valid_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else begin
      case (st_r)
        ST_COLLECT: begin
          if (done_w) begin
            st_r <= ST_SEND;
            tx_idx_r <= IDX_RST;
          end
        end
        ST_SEND: begin
          if (tx_adv_w) begin
            if (tx_more_w) begin
              tx_byte_r <= tx_sel_w;
              tx_valid_r <= 1'b1;
              tx_idx_r <= tx_idx_r + 7'h01;
            end else begin
              tx_valid_r <= 1'b0;
              st_r <= ST_COLLECT;
            end
          end
        end
        default: begin
          st_r <= ST_COLLECT;
          tx_valid_r <= 1'b0;
        end
      endcase
    end
  end

  // motion dispatch; backlash goes away on command, back on first done
  wire logic bk_start_w = (bk_r == BK_IDLE) && cmd_bk_w;
  wire logic bk_ret_w = (bk_r == BK_AWAY) && !bk_abort_w && motion_done_i;

  wire logic abs_set_w = cmd_goto_w || bk_ret_w;
  wire logic rel_set_w = cmd_shift_w || bk_start_w;

  wire logic [31:0] goto_nxt = bk_ret_w ? bk_pos_r : pos_w;
  wire logic [15:0] tfrac_nxt = bk_ret_w ? bk_frac_r : frac_w;
  wire logic [31:0] steps_nxt = bk_start_w ? backlash_dist_i : pos_w;
  wire logic [15:0] sfrac_nxt = bk_start_w ? 16'h0000 : frac_w;

  // dc fraction cleared at capture so the return move matches a goto
  wire logic [15:0] bk_frac_nxt = motor_is_dc_i ? 16'h0000 : cur_frac_i;

  always_comb begin
    bk_nxt = bk_r;
    case (bk_r)
      BK_IDLE: begin
        if (cmd_bk_w) begin
          bk_nxt = BK_AWAY;
        end
      end
      BK_AWAY: begin
        if (bk_abort_w) begin
          bk_nxt = BK_IDLE;
        end else if (motion_done_i) begin
          bk_nxt = BK_BACK;
        end
      end
      BK_BACK: begin
        if (bk_abort_w || motion_done_i) begin
          bk_nxt = BK_IDLE;
        end
      end
      default: begin
        bk_nxt = BK_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      jog_r <= 1'b0;
      pwr_r <= 1'b0;
    end else begin
      jog_r <= cmd_jog_w;
      pwr_r <= cmd_pwr_w;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      abs_r <= 1'b0;
      rel_r <= 1'b0;
    end else begin
      abs_r <= abs_set_w;
      rel_r <= rel_set_w;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      goto_r <= 32'h00000000;
      tfrac_r <= 16'h0000;
    end else if (abs_set_w) begin
      goto_r <= goto_nxt;
      tfrac_r <= tfrac_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      steps_r <= 32'h00000000;
      sfrac_r <= 16'h0000;
      dir_r <= 1'b0;
    end else if (rel_set_w) begin
      steps_r <= steps_nxt;
      sfrac_r <= sfrac_nxt;
      dir_r <= steps_nxt[31];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bk_r <= BK_IDLE;
      bk_pos_r <= 32'h00000000;
      bk_frac_r <= 16'h0000;
    end else begin
      bk_r <= bk_nxt;
      if (bk_start_w) begin
        bk_pos_r <= cur_pos_i;
        bk_frac_r <= bk_frac_nxt;
      end
    end
  end

  assign tx_valid_o = tx_valid_r;
  assign tx_data_o = tx_byte_r;
  assign jog_left_o = jog_r;
  assign move_abs_o = abs_r;
  assign move_rel_o = rel_r;
  assign power_off_o = pwr_r;
  assign goto_pos_o = goto_r;
  assign target_microstep_frac_o = tfrac_r;
  assign shift_steps_o = steps_r;
  assign shift_microstep_frac_o = sfrac_r;
  assign shift_dir_left_o = dir_r;
endmodule
`default_nettype wire

// [verif/mcd_host.sv]
// host model: sends request frames and drains answers
`timescale 1ns/10ps
`default_nettype none
module mcd_host
  import mcd_pkg::*;
(
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
    tx_ready_o = 1'b0;
  end
  task automatic send(input logic [31:0] c, input logic [31:0] p, input logic [15:0] fr);
    logic [143:0] f;
    int n;
    f = {64'h0, fr, p, c};
    n = (c == CMD_GOTO || c == CMD_SHIFT) ? 18 : 4;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = f[8*i+:8];
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    // idle data inverted so a stale byte is never mistaken for a held one
    rx_data_o = ~rx_data_o;
  endtask
  // slow mode stalls every third cycle to exercise byte holding
  task automatic recv(input int n, input bit slow, output logic [607:0] a);
    int k;
    int t;
    k = 0;
    t = 0;
    a = '0;
    while (k < n && t < 500) begin
      @(negedge clk_i);
      t++;
      tx_ready_o = !(slow && t % 3 == 0);
      if (tx_valid_i && tx_ready_o) begin
        a[8*k+:8] = tx_data_i;
        k++;
      end
    end
    repeat (3) @(negedge clk_i);
    tx_ready_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/mcd_decoder_sva.sv]
// port assertions for the motion command decoder
`timescale 1ns/10ps
`default_nettype none
module mcd_decoder_sva (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic motor_is_dc_i,
  input wire logic jog_left_o,
  input wire logic move_abs_o,
  input wire logic move_rel_o,
  input wire logic power_off_o,
  input wire logic [31:0] shift_steps_o,
  input wire logic [15:0] shift_microstep_frac_o,
  input wire logic shift_dir_left_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_jog_echo:
    assert property (jog_left_o |=> tx_valid_o && tx_data_o == 8'h6C) else $error("jog echo bad");
  a_rel_echo:
    assert property (move_rel_o |=> $rose(tx_valid_o)) else $error("shift echo late");
  a_dir_sign:
    assert property (move_rel_o |-> shift_dir_left_o == shift_steps_o[31]) else $error("dir bad");
  a_dc_frac:
    assert property (move_rel_o && motor_is_dc_i |-> shift_microstep_frac_o == 16'h0000)
      else $error("dc fraction kept");
  a_pwr_echo:
    assert property (power_off_o |=> tx_valid_o && tx_data_o == 8'h70) else $error("pwr echo bad");
  a_tx_hold:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("answer byte dropped");
  a_one_pulse:
    assert property ($onehot0({jog_left_o, move_abs_o, move_rel_o, power_off_o}))
      else $error("two motion pulses");
  a_rst_quiet:
    assert property ($fell(srst_i) |-> !tx_valid_o && !move_abs_o) else $error("busy after reset");
  c_jog: cover property (jog_left_o);
  c_abs: cover property (move_abs_o);
  c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule
bind mcd_decoder mcd_decoder_sva mcd_decoder_sva_i (.sys_clk_i, .srst_i, .tx_valid_o,
  .tx_data_o, .tx_ready_i, .motor_is_dc_i, .jog_left_o, .move_abs_o, .move_rel_o,
  .power_off_o, .shift_steps_o, .shift_microstep_frac_o, .shift_dir_left_o);
`default_nettype wire

// [verif/motion_command_decoder_tb.sv]
// bench for the motion command decoder
`timescale 1ns/10ps
`default_nettype none
module motion_command_decoder_tb;
  import mcd_pkg::*;
  typedef struct packed {logic [31:0] c; logic [31:0] p; logic [15:0] f; logic d; logic [3:0] q;} mcd_row_t;
  logic clk = 1'b0, rst = 1'b1, rv, tv, tr, dc = 1'b0, done = 1'b0, jl, ma, mr, po, sd;
  logic [7:0] rd, td;
  logic [31:0] bd = 32'hFFFFFFF0, cp = 32'h00000321, ga, ss;
  logic [15:0] gf, sf;
  logic [207:0] raw, cal;
  logic [3:0] seen = 4'h0;
  logic [607:0] ans;
  int err_total = 0, tests_run = 0, cyc = 0;
  mcd_row_t rows[6] = '{'{CMD_PWR_OFF, 32'h0, 16'h0, 1'b0, 4'h1},
    '{CMD_JOG_LEFT, 32'h0, 16'h0, 1'b0, 4'h8}, '{CMD_BACKLASH, 32'h0, 16'h0, 1'b0, 4'h2},
    '{CMD_GOTO, 32'h12345678, 16'h0155, 1'b0, 4'h4}, '{CMD_GOTO, 32'hFFFFFF00, 16'h0ABC, 1'b1, 4'h4},
    '{CMD_SHIFT, 32'hFFFFFF00, 16'h0077, 1'b0, 4'h2}};
  mcd_decoder mcd_decoder_i (.sys_clk_i(clk), .srst_i(rst), .rx_valid_i(rv), .rx_data_i(rd),
    .tx_valid_o(tv), .tx_data_o(td), .tx_ready_i(tr), .motor_is_dc_i(dc), .backlash_dist_i(bd),
    .cur_pos_i(cp), .cur_frac_i(16'h0055), .motion_done_i(done), .adc_raw_i(raw),
    .adc_cal_i(cal), .wind_res_i(32'h00001234), .wind_ind_i(32'h00005678), .jog_left_o(jl),
    .move_abs_o(ma), .move_rel_o(mr), .power_off_o(po), .goto_pos_o(ga),
    .target_microstep_frac_o(gf), .shift_steps_o(ss), .shift_microstep_frac_o(sf),
    .shift_dir_left_o(sd));
  mcd_host mcd_host_i (.clk_i(clk), .rx_valid_o(rv), .rx_data_o(rd), .tx_valid_i(tv),
    .tx_data_i(td), .tx_ready_o(tr));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    seen <= seen | {jl, ma, mr, po};
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run(input mcd_row_t r);
    logic [15:0] x;
    x = r.d ? 16'h0000 : r.f;
    @(negedge clk);
    dc = r.d;
    seen = 4'h0;
    mcd_host_i.send(r.c, r.p, r.f);
    mcd_host_i.recv(4, 1'b0, ans);
    check("echo", ans[31:0], r.c);
    check("pulse", seen, r.q);
    if (r.q == 4'h4) check("goto", {gf, ga}, {x, r.p});
    if (r.c == CMD_SHIFT) check("shift", {sd, sf, ss}, {r.p[31], x, r.p});
    if (r.c == CMD_BACKLASH) check("away", {sd, sf, ss}, {1'b1, 16'h0, bd});
  endtask
  initial begin
    for (int k = 0; k < 13; k++) begin
      raw[16*k+:16] = 16'h0100 + 16'(k);
      cal[16*k+:16] = 16'h8000 + 16'(k);
    end
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("reset", {tv, jl, ma, mr, po, ga}, 64'h0);
    foreach (rows[i]) run(rows[i]);
    run('{CMD_SHIFT, 32'h00000040, 16'h0033, 1'b1, 4'h2});
    // unknown code must leave no trace, then the collector restarts
    seen = 4'h0;
    mcd_host_i.send(32'h11223344, 32'h0, 16'h0);
    repeat (6) @(negedge clk);
    check("unknown", {tv, seen}, 64'h0);
    run(rows[1]);
    run(rows[2]);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    repeat (2) @(negedge clk);
    check("return", {seen[2], ga}, {1'b1, cp});
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    mcd_host_i.send(CMD_ANALOG, 32'h0, 16'h0);
    mcd_host_i.recv(76, 1'b1, ans);
    check("analog", 64'(ans === {96'h0, 32'h00005678, 32'h00001234, 16'h0, cal, raw,
      CMD_ANALOG}), 64'h1);
    conclude();
  end
endmodule
`default_nettype wire
